//--- pmc_pkg.sv
// pmc_pkg: constants, register map and state codes of the power mode controller
// assumes a single 250 MHz clock and an AXI4-Lite register port
package pmc_pkg;
  localparam int AXI_ADDR_W = 8;
  localparam int CLK_PERIOD_PS = 4000;
  // register byte offsets
  localparam logic [7:0] PWR_CTRL_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] WAKE_EN_OFF = 8'h08;
  // power_control_register fields
  localparam int IDLE_REQ_BIT = 0;
  localparam int PDOWN_REQ_BIT = 1;
  localparam int GFLAG0_BIT = 2;
  localparam int GFLAG1_BIT = 3;
  localparam logic [3:0] PWR_CTRL_RST = 4'h0;
  // wake enable register fields
  localparam int EXT0_EN_BIT = 0;
  localparam int EXT1_EN_BIT = 1;
  localparam int ADC_IDLE_BIT = 2;
  localparam logic [2:0] WAKE_EN_RST = 3'h0;
  // status register: state in [5:0], sticky wake causes from this position
  localparam int CAUSE_LSB = 8;
  localparam int CAUSE_IRQ = 0;
  localparam int CAUSE_ADC = 1;
  localparam int CAUSE_EXT = 2;
  localparam int CAUSE_RST = 3;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  // brief execution after a reset wake-up, then internal reset hold
  localparam int RST_RUN_NS = 48;
  localparam int RST_HOLD_NS = 96;
  localparam int RST_RUN_CYC = (RST_RUN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RST_HOLD_CYC = (RST_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [5:0] {
    ST_RUN = 6'b000001,
    ST_IDLE = 6'b000010,
    ST_PDOWN = 6'b000100,
    ST_PD_EXIT = 6'b001000,
    ST_RST_RUN = 6'b010000,
    ST_RST_HOLD = 6'b100000
  } pmc_state_t;
endpackage : pmc_pkg

//--- pmc_pin_if.sv
// pmc_pin_if: synchronised pin levels passed from the synchroniser to the controller
// assumes all members live in the aclk domain
`timescale 1ns/1ps
`default_nettype none
interface pmc_pin_if;
  logic rst_s;
  logic ext0_n_s;
  logic ext1_n_s;
  modport sync (output rst_s, output ext0_n_s, output ext1_n_s);
  modport ctrl (input rst_s, input ext0_n_s, input ext1_n_s);
endinterface : pmc_pin_if
`default_nettype wire

//--- pmc_sync.sv
// pmc_sync: two-flop synchronisers for the reset pin and the wake interrupt pins
// assumes raw pins are asynchronous to aclk
`timescale 1ns/1ps
`default_nettype none
module pmc_sync
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] pins_raw,
  pmc_pin_if.sync pins
);
  import pmc_pkg::*;
  // idle levels: reset pin low, interrupt pins high
  localparam logic [2:0] PIN_IDLE = 3'h6;
  logic [2:0] meta_r;
  logic [2:0] sync_r;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_bit
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          meta_r[gi] <= PIN_IDLE[gi];
          sync_r[gi] <= PIN_IDLE[gi];
        end
        else
        begin
          meta_r[gi] <= pins_raw[gi];
          sync_r[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate
  assign pins.rst_s = sync_r[0];
  assign pins.ext0_n_s = sync_r[1];
  assign pins.ext1_n_s = sync_r[2];
endmodule : pmc_sync
`default_nettype wire

//--- pmc_power_ctrl.sv
// pmc_power_ctrl: idle and power-down sequencing with an AXI4-Lite register port
// assumes the cpu pulses insn_done at each instruction end and irq inputs are on aclk
`timescale 1ns/1ps
`default_nettype none
module pmc_power_ctrl
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [pmc_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pmc_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rst_pin,
  input wire logic ext_irq_zero_n,
  input wire logic ext_irq_one_n,
  input wire logic insn_done,
  input wire logic irq_req,
  input wire logic irq_en,
  input wire logic adc_done,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic osc_run,
  output logic cpu_hold,
  output logic ram_block,
  output logic sfr_reset,
  output logic port_force_high,
  output logic port_hold,
  output logic cpu_restart,
  output logic [15:0] restart_addr
);
  import pmc_pkg::*;

  pmc_pin_if pins ();

  pmc_sync i_pmc_sync
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .pins_raw({ext_irq_one_n, ext_irq_zero_n, rst_pin}),
    .pins(pins)
  );

  pmc_state_t state_r;
  pmc_state_t state_nxt;
  logic [7:0] cnt_r;
  logic idle_request_bit_r;
  logic powerdown_request_bit_r;
  logic general_flag_zero_r;
  logic general_flag_one_r;
  logic [2:0] wake_en_r;
  logic adc_mode_r;
  logic [3:0] cause_r;
  logic [3:0] cause_set;
  logic clr_idle;
  logic clr_pdown;
  logic ext_low;
  logic irq_wake;
  logic [AXI_ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic aw_full_r;
  logic w_full_r;
  logic wr_fire;
  logic wr_pctl;
  logic wr_wake;
  logic wr_stat;
  logic in_sfr_reset;

  // only enabled interrupt pins count as an external wake source
  assign ext_low = (wake_en_r[EXT0_EN_BIT] & ~pins.ext0_n_s) |
                   (wake_en_r[EXT1_EN_BIT] & ~pins.ext1_n_s);
  assign irq_wake = irq_req & irq_en;
  assign in_sfr_reset = (state_r == ST_RST_HOLD);

  // ---------------- axi4-lite write channel ----------------
  assign wr_fire = aw_full_r & w_full_r & ~s_axi_bvalid;
  assign wr_pctl = wr_fire && (aw_addr_r == PWR_CTRL_OFF) && w_strb_r[0];
  assign wr_wake = wr_fire && (aw_addr_r == WAKE_EN_OFF) && w_strb_r[0];
  assign wr_stat = wr_fire && (aw_addr_r == STATUS_OFF) && w_strb_r[1];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= ~aw_full_r & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready <= ~w_full_r & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        if (aw_addr_r == PWR_CTRL_OFF || aw_addr_r == STATUS_OFF || aw_addr_r == WAKE_EN_OFF)
          s_axi_bresp <= RESP_OKAY;
        else
          s_axi_bresp <= RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ---------------- axi4-lite read channel ----------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      if (s_axi_araddr == PWR_CTRL_OFF)
        s_axi_rdata <= {28'h000_0000, general_flag_one_r, general_flag_zero_r,
                        powerdown_request_bit_r, idle_request_bit_r};
      else if (s_axi_araddr == STATUS_OFF)
        s_axi_rdata <= {20'h0_0000, cause_r, 2'h0, state_r};
      else if (s_axi_araddr == WAKE_EN_OFF)
        s_axi_rdata <= {29'h0000_0000, wake_en_r};
      else
      begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

  // ---------------- sequencer ----------------
  always_comb
  begin
    state_nxt = state_r;
    clr_idle = 1'b0;
    clr_pdown = 1'b0;
    cause_set = 4'h0;
    case (state_r)
      ST_RUN:
      begin
        if (pins.rst_s)
          state_nxt = ST_RST_HOLD;
        else if (insn_done && powerdown_request_bit_r)
          state_nxt = ST_PDOWN;
        else if (insn_done && idle_request_bit_r)
          state_nxt = ST_IDLE;
      end
      ST_IDLE:
      begin
        if (pins.rst_s)
        begin
          state_nxt = ST_RST_RUN;
          clr_idle = 1'b1;
          cause_set[CAUSE_RST] = 1'b1;
        end
        else if (irq_wake)
        begin
          state_nxt = ST_RUN;
          clr_idle = 1'b1;
          cause_set[CAUSE_IRQ] = 1'b1;
        end
        else if (adc_mode_r && adc_done)
        begin
          state_nxt = ST_RUN;
          clr_idle = 1'b1;
          cause_set[CAUSE_ADC] = 1'b1;
        end
      end
      ST_PDOWN:
      begin
        if (pins.rst_s)
        begin
          state_nxt = ST_RST_RUN;
          clr_idle = 1'b1;
          clr_pdown = 1'b1;
          cause_set[CAUSE_RST] = 1'b1;
        end
        else if (ext_low)
        begin
          // idle bit dropped too, so the wake never falls into idle
          state_nxt = ST_PD_EXIT;
          clr_idle = 1'b1;
          clr_pdown = 1'b1;
          cause_set[CAUSE_EXT] = 1'b1;
        end
      end
      ST_PD_EXIT:
      begin
        // the held interrupt doubles as the oscillator settling time
        if (pins.rst_s)
          state_nxt = ST_RST_RUN;
        else if (!ext_low)
          state_nxt = ST_RUN;
      end
      ST_RST_RUN:
      begin
        if (cnt_r == 8'(RST_RUN_CYC - 1))
          state_nxt = ST_RST_HOLD;
      end
      ST_RST_HOLD:
      begin
        if (cnt_r >= 8'(RST_HOLD_CYC - 1) && !pins.rst_s)
          state_nxt = ST_RUN;
      end
      default:
        state_nxt = ST_RST_HOLD;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= ST_RUN;
      cnt_r <= 8'h00;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_nxt != state_r)
        cnt_r <= 8'h00;
      else if (cnt_r != 8'hff)
        cnt_r <= cnt_r + 8'h01;
    end
  end

  // ---------------- power control register ----------------
  // a software set in the same cycle as a hardware clear wins; it only re-arms a request
  always_ff @(posedge aclk)
  begin
    if (!aresetn || in_sfr_reset)
    begin
      idle_request_bit_r <= PWR_CTRL_RST[IDLE_REQ_BIT];
      powerdown_request_bit_r <= PWR_CTRL_RST[PDOWN_REQ_BIT];
      general_flag_zero_r <= PWR_CTRL_RST[GFLAG0_BIT];
      general_flag_one_r <= PWR_CTRL_RST[GFLAG1_BIT];
      wake_en_r <= WAKE_EN_RST;
    end
    else
    begin
      if (wr_pctl)
      begin
        idle_request_bit_r <= w_data_r[IDLE_REQ_BIT];
        powerdown_request_bit_r <= w_data_r[PDOWN_REQ_BIT];
        general_flag_zero_r <= w_data_r[GFLAG0_BIT];
        general_flag_one_r <= w_data_r[GFLAG1_BIT];
      end
      else
      begin
        if (clr_idle)
          idle_request_bit_r <= 1'b0;
        if (clr_pdown)
          powerdown_request_bit_r <= 1'b0;
      end
      if (wr_wake)
        wake_en_r <= w_data_r[2:0];
    end
  end

  // converter idle mode is latched at entry so a later write cannot change the exit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      adc_mode_r <= 1'b0;
    else if (state_r == ST_RUN && state_nxt == ST_IDLE)
      adc_mode_r <= wake_en_r[ADC_IDLE_BIT];
  end

  // sticky wake causes: write one to clear, a new event wins over the clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cause_r <= 4'h0;
    else if (wr_stat)
      cause_r <= (cause_r & ~w_data_r[CAUSE_LSB +: 4]) | cause_set;
    else
      cause_r <= cause_r | cause_set;
  end

  // ---------------- clock, hold and port controls ----------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cpu_clk_en <= 1'b0;
      periph_clk_en <= 1'b0;
      osc_run <= 1'b1;
      cpu_hold <= 1'b0;
      ram_block <= 1'b0;
      sfr_reset <= 1'b1;
      port_force_high <= 1'b1;
      port_hold <= 1'b0;
      cpu_restart <= 1'b0;
      restart_addr <= RESET_VECTOR;
    end
    else
    begin
      cpu_clk_en <= (state_nxt == ST_RUN) || (state_nxt == ST_RST_RUN);
      periph_clk_en <= (state_nxt != ST_PDOWN);
      osc_run <= (state_nxt != ST_PDOWN);
      // hold freezes pc, status word, sfr and ram writes
      cpu_hold <= (state_nxt == ST_IDLE) || (state_nxt == ST_PDOWN) ||
                  (state_nxt == ST_PD_EXIT);
      ram_block <= (state_nxt == ST_RST_RUN) || (state_nxt == ST_RST_HOLD);
      sfr_reset <= (state_nxt == ST_RST_HOLD);
      port_force_high <= (state_nxt == ST_RST_HOLD);
      port_hold <= (state_nxt == ST_IDLE) || (state_nxt == ST_PDOWN) ||
                   (state_nxt == ST_PD_EXIT);
      cpu_restart <= (state_r == ST_RST_HOLD) && (state_nxt == ST_RUN);
      restart_addr <= RESET_VECTOR;
    end
  end

  // ---------------- assertions ----------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_idle_clk_gate: assert property (state_r == ST_IDLE |-> !cpu_clk_en && periph_clk_en)
    else $error("idle must gate only the cpu clock");
  a_idle_entry: assert property (state_r == ST_RUN && insn_done && idle_request_bit_r &&
    !powerdown_request_bit_r && !pins.rst_s |=> state_r == ST_IDLE && cpu_hold)
    else $error("idle not entered after request");
  a_both_bits_pd: assert property (state_r == ST_RUN && insn_done && powerdown_request_bit_r &&
    !pins.rst_s |=> state_r == ST_PDOWN)
    else $error("power-down must win over idle");
  a_pd_no_idle: assert property (state_r == ST_PD_EXIT && !ext_low && !pins.rst_s
    |=> state_r == ST_RUN ##1 state_r != ST_IDLE)
    else $error("power-down exit fell into idle");
  a_irq_wake: assert property (state_r == ST_IDLE && irq_wake && !pins.rst_s && !wr_pctl
    |=> !idle_request_bit_r && cpu_clk_en && state_r == ST_RUN)
    else $error("enabled interrupt did not end idle");
  a_rst_idle: assert property (state_r == ST_IDLE && pins.rst_s && !wr_pctl
    |=> !idle_request_bit_r && cpu_clk_en)
    else $error("reset pin did not end idle");
  a_ram_block: assert property ($rose(state_r == ST_RST_RUN) |-> ram_block && cpu_clk_en)
    else $error("ram not blocked after reset wake");
  a_pd_osc_stop: assert property (state_r == ST_PDOWN |-> !osc_run && !periph_clk_en && !cpu_clk_en)
    else $error("clocks running in power-down");
  a_no_en_irq: assert property (state_r == ST_IDLE && !irq_wake && !adc_done && !pins.rst_s
    |=> state_r == ST_IDLE && !cpu_clk_en)
    else $error("disabled interrupt woke the cpu");
  a_rst_hold_len: assert property ($rose(state_r == ST_RST_HOLD) |-> (port_force_high && sfr_reset)[*8])
    else $error("reset hold too short");
endmodule : pmc_power_ctrl
`default_nettype wire

//--- pmc_cpu_model.sv
// pmc_cpu_model: behavioural cpu core, retires one instruction per step request while cpu_clk_en is high
// assumes step is driven on aclk by the bench
`timescale 1ns/1ps
`default_nettype none
module pmc_cpu_model
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cpu_clk_en,
  input wire logic step,
  output logic insn_done
);
  // a gated core retires nothing, so the requesting instruction is the last one
  // the instruction after a request never touches ports or external ram
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      insn_done <= 1'b0;
    else
      insn_done <= step && cpu_clk_en;
  end
endmodule : pmc_cpu_model
`default_nettype wire

//--- power_mode_controller_tb.sv
// power_mode_controller_tb: register tests and power mode sequences over AXI4-Lite
// assumes the controller top, its package and the cpu model are compiled first
`timescale 1ns/1ps
`default_nettype none
module power_mode_controller_tb;
  import pmc_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic rst_pin = 1'b0, ext0_n = 1'b1, ext1_n = 1'b1, step = 1'b0, insn_done;
  logic irq_req = 1'b0, irq_en = 1'b0, adc_done = 1'b0;
  logic cpu_clk_en, periph_clk_en, osc_run, cpu_hold, ram_block, sfr_reset, port_force_high, port_hold;
  logic cpu_restart;
  logic [15:0] restart_addr;
  logic [8:0] mon;
  logic [31:0] d;
  int failures = 0, n_compared = 0;
  // mon: 0 cpu clk, 1 periph clk, 2 osc, 3 hold, 4 port hold, 5 ram block, 6 sfr reset, 7 ports high, 8 restart
  assign mon = {cpu_restart, port_force_high, sfr_reset, ram_block, port_hold, cpu_hold, osc_run,
                periph_clk_en, cpu_clk_en};
  always #2 aclk = ~aclk;
  pmc_power_ctrl i_pmc_power_ctrl (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rst_pin(rst_pin), .ext_irq_zero_n(ext0_n), .ext_irq_one_n(ext1_n), .insn_done(insn_done),
    .irq_req(irq_req), .irq_en(irq_en), .adc_done(adc_done), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .osc_run(osc_run), .cpu_hold(cpu_hold), .ram_block(ram_block),
    .sfr_reset(sfr_reset), .port_force_high(port_force_high), .port_hold(port_hold),
    .cpu_restart(cpu_restart), .restart_addr(restart_addr));
  pmc_cpu_model i_pmc_cpu_model (.aclk(aclk), .aresetn(aresetn), .cpu_clk_en(cpu_clk_en), .step(step),
    .insn_done(insn_done));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    int t;
    t = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    r = 2'h3;
    while (t < 100 && r === 2'h3)
    begin
      @(posedge aclk);
      t++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
      end
    end
    chk("write answered", 32'h1, t < 100);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    int t;
    t = 0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    r = 2'h3;
    while (t < 100 && r === 2'h3)
    begin
      @(posedge aclk);
      t++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        r = rresp;
        v = rdata;
        rready <= 1'b0;
      end
    end
    chk("read answered", 32'h1, t < 100);
  endtask : axi_rd

  task automatic wait_bit(input int i, input logic v, input int lim);
    int t;
    t = 0;
    do
    begin
      @(posedge aclk);
      t++;
    end
    while (mon[i] !== v && t < lim);
    chk($sformatf("mon bit %0d", i), v, mon[i]);
  endtask : wait_bit

  // one-cycle strobe on the cpu step or on the conversion-complete input
  task automatic pulse(input bit to_adc);
    @(posedge aclk);
    if (to_adc)
      adc_done <= 1'b1;
    else
      step <= 1'b1;
    @(posedge aclk);
    step <= 1'b0;
    adc_done <= 1'b0;
  endtask : pulse

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    axi_rd(a, d, resp);
    chk("reg", e, d & 32'h0000_000f);
  endtask : rd_chk

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  initial
  begin
    #40000;
    failures++;
    complete_run();
  end

  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("clk after reset", 32'h1, cpu_clk_en & osc_run);
    rd_chk(PWR_CTRL_OFF, 32'h0);
    rd_chk(WAKE_EN_OFF, 32'h0);
    axi_rd(8'h0c, d, resp);
    chk("unmapped rresp", RESP_SLVERR, resp);
    axi_wr(8'h10, 32'h1, resp);
    chk("unmapped bresp", RESP_SLVERR, resp);
    // idle, a disabled request, then an enabled one
    axi_wr(PWR_CTRL_OFF, 32'h1, resp);
    pulse(1'b0);
    wait_bit(0, 1'b0, 10);
    chk("idle state", 32'h1e, mon[4:0]);
    irq_req <= 1'b1;
    repeat (10) @(posedge aclk);
    chk("disabled irq", 32'h0, cpu_clk_en);
    irq_en <= 1'b1;
    wait_bit(0, 1'b1, 5);
    irq_req <= 1'b0;
    irq_en <= 1'b0;
    rd_chk(PWR_CTRL_OFF, 32'h0);
    // status shows the run state and the sticky interrupt cause, then write one clears it
    axi_rd(STATUS_OFF, d, resp);
    chk("status irq cause", 32'h0000_0101, d);
    axi_wr(STATUS_OFF, 32'h0000_0f00, resp);
    axi_rd(STATUS_OFF, d, resp);
    chk("status cleared", 32'h0000_0001, d);
    // idle entered in converter mode leaves on conversion complete
    axi_wr(WAKE_EN_OFF, 32'h4, resp);
    axi_wr(PWR_CTRL_OFF, 32'h1, resp);
    pulse(1'b0);
    wait_bit(0, 1'b0, 10);
    pulse(1'b1);
    wait_bit(0, 1'b1, 5);
    // both request bits and flags in one write, external wake
    axi_wr(WAKE_EN_OFF, 32'h1, resp);
    axi_wr(PWR_CTRL_OFF, 32'hf, resp);
    pulse(1'b0);
    wait_bit(2, 1'b0, 10);
    chk("pd clocks", 32'h8, mon[3:0]);
    ext0_n <= 1'b0; // held low across oscillator start
    wait_bit(2, 1'b1, 10);
    repeat (30) @(posedge aclk);
    chk("held until release", 32'h1, cpu_hold);
    ext0_n <= 1'b1;
    wait_bit(3, 1'b0, 10);
    repeat (5) @(posedge aclk);
    chk("running after pd", 32'h1, cpu_clk_en);
    rd_chk(PWR_CTRL_OFF, 32'hc);
    // only the second pin enabled: the first must not wake, the second must
    axi_wr(WAKE_EN_OFF, 32'h2, resp);
    axi_wr(PWR_CTRL_OFF, 32'h2, resp);
    pulse(1'b0);
    wait_bit(2, 1'b0, 10);
    ext0_n <= 1'b0;
    repeat (10) @(posedge aclk);
    chk("disabled ext pin", 32'h0, osc_run);
    ext1_n <= 1'b0; // held low across oscillator start
    wait_bit(2, 1'b1, 10);
    ext0_n <= 1'b1;
    ext1_n <= 1'b1;
    wait_bit(0, 1'b1, 10);
    // reset pin wake from idle then from power-down
    for (int m = 1; m < 3; m++)
    begin
      axi_wr(PWR_CTRL_OFF, m | 8, resp);
      pulse(1'b0);
      wait_bit(0, 1'b0, 10);
      rst_pin <= 1'b1;
      wait_bit(5, 1'b1, 10);
      chk("reset run", 32'h5, mon[2:0] & 3'h5);
      wait_bit(6, 1'b1, 20);
      chk("ports high", 32'h1, port_force_high);
      rd_chk(PWR_CTRL_OFF, 32'h0);
      rst_pin <= 1'b0;
      wait_bit(8, 1'b1, 60);
      chk("vector", RESET_VECTOR, restart_addr);
    end
    complete_run();
  end
endmodule : power_mode_controller_tb
`default_nettype wire
